// ---- hw/irq_agg_pkg.sv ----
// Package: register map, field positions and reset values for the interrupt aggregator.
// Assumes a byte-wide register port driven by the device's local serial slave.
// Contract
// - Drive active-low interrupt from control and status
// - Three sources: receive ports 0, 1, transmit
// - Only source status reads clear pending conditions
// - Flags set regardless of enables
// - Interrupt selectable onto general-purpose pins
// - Output needs source enable and global enable
// - Flag visible while global enable clear
// - Control bit7 global, bit0 port0, bit1 port1
// - Per-port enables at high and low registers
// - Port flag registers read-only mirror status
// - Reading link or camera status clears condition
// - Status bits: 7 global, 4 transmit, 1, 0
// - Low and high flag bit assignments
// - Port registers reached through port paging
package irq_agg_pkg;
    localparam logic [7:0] ADDR_MAIN_CTL = 8'h23;
    localparam logic [7:0] ADDR_MAIN_STS = 8'h24;
    localparam logic [7:0] ADDR_PORT_SEL = 8'h4C;
    localparam logic [7:0] ADDR_LINK_STS1 = 8'h4D;
    localparam logic [7:0] ADDR_LINK_STS2 = 8'h4E;
    localparam logic [7:0] ADDR_CAM_STS = 8'h7A;
    localparam logic [7:0] ADDR_PIN_CTL = 8'h10;
    localparam logic [7:0] ADDR_EN_HI = 8'hD8;
    localparam logic [7:0] ADDR_EN_LO = 8'hD9;
    localparam logic [7:0] ADDR_FLG_HI = 8'hDA;
    localparam logic [7:0] ADDR_FLG_LO = 8'hDB;
    localparam int NUM_PINS = 4;
    localparam int PIN_CTL_W = 2;
    localparam int PIN_FUNC_IRQ = 1;
    localparam int BIT_GLOBAL = 7;
    localparam int BIT_TX = 4;
    localparam int BIT_RX1 = 1;
    localparam int BIT_RX0 = 0;
    localparam int NUM_LO = 7;
    localparam int NUM_HI = 3;
    localparam int LO_CAM_ERR = 3;
    localparam logic [7:0] LO_STS2_MASK = 8'h76;
    localparam logic [7:0] LO_STS1_MASK = 8'h01;
    localparam logic [7:0] LO_CAM_MASK = 8'h08;
    localparam logic [7:0] HI_STS1_MASK = 8'h03;
    localparam logic [7:0] HI_STS2_MASK = 8'h04;
    localparam logic [7:0] RESET_BYTE = 8'h00;
endpackage

// ---- hw/irq_aggregator.sv ----
// Interrupt aggregator: per-port and transmit flags, enables, combined level output.
// Assumes register strobes are one-cycle pulses in the clk_i domain.
`timescale 1ns/1ps
module irq_aggregator (
    input wire logic clk_i, // 50 MHz clock
    input wire logic nrst_i, // Synchronous reset, low
    input wire logic reg_wr_i, // Register write strobe
    input wire logic reg_rd_i, // Register read strobe
    input wire logic [7:0] reg_addr_i, // Register offset
    input wire logic [7:0] reg_wdata_i, // Write data
    output logic [7:0] reg_rdata_o, // Read data, registered
    input wire logic [1:0][irq_agg_pkg::NUM_LO-1:0] lo_event_i, // Low-group events per port
    input wire logic [1:0][irq_agg_pkg::NUM_HI-1:0] hi_event_i, // High-group events per port
    input wire logic tx_irq_i, // Transmit port interrupt level
    input wire logic tx_sts_rd_i, // Transmit status read, for its clear
    output logic interrupt_out_n_o, // Dedicated interrupt, low active
    output logic [irq_agg_pkg::NUM_PINS-1:0] pin_out_o, // Pin data
    output logic [irq_agg_pkg::NUM_PINS-1:0] pin_oe_o // Pin drive enable
);
    import irq_agg_pkg::*;

    function automatic logic [7:0] sts_clear_lo(input logic [7:0] a);
        sts_clear_lo = (a == ADDR_LINK_STS1) ? LO_STS1_MASK :
                       (a == ADDR_LINK_STS2) ? LO_STS2_MASK :
                       (a == ADDR_CAM_STS) ? LO_CAM_MASK : RESET_BYTE;
    endfunction

    function automatic logic [7:0] sts_clear_hi(input logic [7:0] a);
        sts_clear_hi = (a == ADDR_LINK_STS1) ? HI_STS1_MASK :
                       (a == ADDR_LINK_STS2) ? HI_STS2_MASK : RESET_BYTE;
    endfunction

    // Paged read view: port 1 wins when both ports are selected
    function automatic logic [7:0] paged_view(input logic [7:0] sel,
                                              input logic [1:0][7:0] regs);
        paged_view = sel[1] ? regs[1] : regs[0];
    endfunction

    logic [7:0] ctl_reg, ctl_next;
    logic [7:0] sel_reg, sel_next;
    logic [1:0][7:0] en_hi_reg, en_hi_next;
    logic [1:0][7:0] en_lo_reg, en_lo_next;
    logic [1:0][7:0] fl_hi_reg, fl_hi_next;
    logic [1:0][7:0] fl_lo_reg, fl_lo_next;
    logic [1:0][7:0] lo_meta_reg, lo_meta_next, lo_sync_reg, lo_sync_next;
    logic [1:0][7:0] hi_meta_reg, hi_meta_next, hi_sync_reg, hi_sync_next;
    logic [2:0] tx_sync_reg, tx_sync_next;
    logic tx_flag_reg, tx_flag_next;
    logic [NUM_PINS-1:0][PIN_CTL_W-1:0] pin_reg, pin_next;
    logic [7:0] rdata_next, sts_view;
    logic [1:0] port_pend;
    logic irq_next;
    logic irq_n_next;
    logic [NUM_PINS-1:0] pin_out_next, pin_oe_next;

    // Two-stage synchronisers: the second stage feeds the port flags; transmit takes stages two and three
    always_comb begin
        for (int p = 0; p < 2; p++) begin
            lo_meta_next[p] = {1'b0, lo_event_i[p]};
            hi_meta_next[p] = {5'h00, hi_event_i[p]};
        end
        lo_sync_next = lo_meta_reg;
        hi_sync_next = hi_meta_reg;
        tx_sync_next = {tx_sync_reg[1:0], tx_irq_i};
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            lo_meta_reg <= '0;
            lo_sync_reg <= '0;
            hi_meta_reg <= '0;
            hi_sync_reg <= '0;
            tx_sync_reg <= '0;
        end else begin
            lo_meta_reg <= lo_meta_next;
            lo_sync_reg <= lo_sync_next;
            hi_meta_reg <= hi_meta_next;
            hi_sync_reg <= hi_sync_next;
            tx_sync_reg <= tx_sync_next;
        end
    end

    // Control, paging and enable registers
    always_comb begin
        ctl_next = ctl_reg;
        sel_next = sel_reg;
        en_hi_next = en_hi_reg;
        en_lo_next = en_lo_reg;
        pin_next = pin_reg;
        // Writes never touch flags
        if (reg_wr_i) begin
            case (reg_addr_i)
                ADDR_MAIN_CTL: ctl_next = reg_wdata_i;
                ADDR_PORT_SEL: sel_next = reg_wdata_i;
                ADDR_PIN_CTL: pin_next = reg_wdata_i;
                ADDR_EN_HI: begin
                    for (int p = 0; p < 2; p++) begin
                        if (sel_reg[p]) en_hi_next[p] = reg_wdata_i;
                    end
                end
                ADDR_EN_LO: begin
                    for (int p = 0; p < 2; p++) begin
                        if (sel_reg[p]) en_lo_next[p] = reg_wdata_i;
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            ctl_reg <= RESET_BYTE;
            sel_reg <= RESET_BYTE;
            en_hi_reg <= '0;
            en_lo_reg <= '0;
            pin_reg <= '0;
        end else begin
            ctl_reg <= ctl_next;
            sel_reg <= sel_next;
            en_hi_reg <= en_hi_next;
            en_lo_reg <= en_lo_next;
            pin_reg <= pin_next;
        end
    end

    // Per-port flag latches: the paged status read clears, a same-cycle event re-sets
    for (genvar gp = 0; gp < 2; gp++) begin : g_port
        always_comb begin
            fl_lo_next[gp] = fl_lo_reg[gp];
            fl_hi_next[gp] = fl_hi_reg[gp];
            if (reg_rd_i && sel_reg[gp]) begin
                fl_lo_next[gp] = fl_lo_reg[gp] & ~sts_clear_lo(reg_addr_i);
                fl_hi_next[gp] = fl_hi_reg[gp] & ~sts_clear_hi(reg_addr_i);
            end
            fl_lo_next[gp] = fl_lo_next[gp] | lo_sync_reg[gp];
            fl_hi_next[gp] = fl_hi_next[gp] | hi_sync_reg[gp];
        end

        always_ff @(posedge clk_i) begin
            if (!nrst_i) begin
                fl_lo_reg[gp] <= RESET_BYTE;
                fl_hi_reg[gp] <= RESET_BYTE;
            end else begin
                fl_lo_reg[gp] <= fl_lo_next[gp];
                fl_hi_reg[gp] <= fl_hi_next[gp];
            end
        end

        // A port is pending only through its own enabled conditions
        assign port_pend[gp] = |(fl_lo_reg[gp] & en_lo_reg[gp]) |
                               |(fl_hi_reg[gp] & en_hi_reg[gp]);
    end

    // Transmit source flag, set on a rising level
    always_comb begin
        tx_flag_next = tx_flag_reg;
        if (tx_sts_rd_i) tx_flag_next = 1'b0;
        if (tx_sync_reg[1] && !tx_sync_reg[2]) tx_flag_next = 1'b1;
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            tx_flag_reg <= 1'b0;
        end else begin
            tx_flag_reg <= tx_flag_next;
        end
    end

    // Status view, interrupt level, pin drive and read data
    always_comb begin
        sts_view = RESET_BYTE;
        sts_view[BIT_RX0] = port_pend[0];
        sts_view[BIT_RX1] = port_pend[1];
        sts_view[BIT_TX] = tx_flag_reg;
        sts_view[BIT_GLOBAL] = (port_pend[0] & ctl_reg[BIT_RX0]) |
                               (port_pend[1] & ctl_reg[BIT_RX1]) |
                               (tx_flag_reg & ctl_reg[BIT_TX]);
        irq_next = sts_view[BIT_GLOBAL] & ctl_reg[BIT_GLOBAL];
        irq_n_next = ~irq_next;
        for (int i = 0; i < NUM_PINS; i++) begin
            // Open-drain style: drive low while interrupt active, only on pins set to the interrupt function
            pin_out_next[i] = 1'b0;
            pin_oe_next[i] = (pin_reg[i] == PIN_CTL_W'(PIN_FUNC_IRQ)) && irq_next;
        end
        case (reg_addr_i)
            ADDR_MAIN_CTL: rdata_next = ctl_reg;
            ADDR_MAIN_STS: rdata_next = sts_view;
            ADDR_PORT_SEL: rdata_next = sel_reg;
            ADDR_PIN_CTL: rdata_next = pin_reg;
            ADDR_EN_HI: rdata_next = paged_view(sel_reg, en_hi_reg);
            ADDR_EN_LO: rdata_next = paged_view(sel_reg, en_lo_reg);
            ADDR_FLG_HI: rdata_next = paged_view(sel_reg, fl_hi_reg);
            ADDR_FLG_LO: rdata_next = paged_view(sel_reg, fl_lo_reg);
            default: rdata_next = RESET_BYTE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            reg_rdata_o <= RESET_BYTE;
            interrupt_out_n_o <= 1'b1;
            pin_out_o <= '0;
            pin_oe_o <= '0;
        end else begin
            reg_rdata_o <= rdata_next;
            interrupt_out_n_o <= irq_n_next;
            pin_out_o <= pin_out_next;
            pin_oe_o <= pin_oe_next;
        end
    end
endmodule // irq_aggregator

// ---- tb/irq_agg_sva.sv ----
// Checker: port timing of the interrupt aggregator.
// Assumes a bind onto irq_aggregator, one clock domain.
`timescale 1ns/1ps
module irq_agg_sva (
    input wire logic clk_i, // Clock
    input wire logic nrst_i, // Reset, low
    input wire logic reg_wr_i, // Write strobe
    input wire logic reg_rd_i, // Read strobe
    input wire logic [7:0] reg_addr_i, // Offset
    input wire logic [7:0] reg_wdata_i, // Write data
    input wire logic [7:0] reg_rdata_o, // Read data
    input wire logic tx_irq_i, // Transmit level
    input wire logic tx_sts_rd_i, // Transmit clear
    input wire logic interrupt_out_n_o, // Interrupt, low
    input wire logic [irq_agg_pkg::NUM_PINS-1:0] pin_out_o, // Pin data
    input wire logic [irq_agg_pkg::NUM_PINS-1:0] pin_oe_o // Pin enable
);
    import irq_agg_pkg::*;
    logic [7:0] ctl_reg;
    always_ff @(posedge clk_i) begin
        if (!nrst_i) ctl_reg <= 8'h00;
        else if (reg_wr_i && reg_addr_i == ADDR_MAIN_CTL) ctl_reg <= reg_wdata_i;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    AST_RST_IDLE: assert property ($rose(nrst_i) |-> interrupt_out_n_o && !(|pin_oe_o))
        else $error("outputs active after reset");
    AST_PIN_DATA: assert property (pin_out_o == '0)
        else $error("pin data not low");
    AST_PIN_OE: assert property (|pin_oe_o |-> !interrupt_out_n_o)
        else $error("pin driven without interrupt");
    AST_CLEAR_CAUSE: assert property ($rose(interrupt_out_n_o) |->
        $past(reg_rd_i, 2) || $past(reg_wr_i, 2) || $past(tx_sts_rd_i, 2))
        else $error("interrupt released without access");
    AST_CTL_BACK: assert property ((reg_wr_i && reg_addr_i == ADDR_MAIN_CTL
        && (reg_wdata_i & 8'h6C) == 8'h00) ##1 (reg_addr_i == ADDR_MAIN_CTL && !reg_wr_i)
        |=> reg_rdata_o == $past(reg_wdata_i, 2))
        else $error("control readback wrong");
    AST_UNMAPPED: assert property (reg_addr_i == 8'hFF |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    AST_GLOBAL_OFF: assert property (!ctl_reg[7] |=> interrupt_out_n_o)
        else $error("interrupt without global enable");
    AST_SRC_OFF: assert property ((ctl_reg & 8'h13) == 8'h00 |=> interrupt_out_n_o)
        else $error("interrupt without source enable");
    AST_TX_SET: assert property (ctl_reg[7] && ctl_reg[4] && $rose(tx_irq_i)
        |-> ##[1:6] !interrupt_out_n_o)
        else $error("transmit source not raised");
    cover property (!interrupt_out_n_o);
    cover property ($rose(interrupt_out_n_o));
    cover property (|pin_oe_o);
endmodule // irq_agg_sva

// ---- tb/irq_host_model.sv ----
// Host model: byte register cycles toward the slave port.
// Assumes one clock; strobes last one cycle.
`timescale 1ns/1ps
module irq_host_model (
    input wire logic clk_i, // Device clock
    input wire logic [7:0] reg_rdata_i, // Read data
    output logic reg_wr_o, // Write strobe
    output logic reg_rd_o, // Read strobe
    output logic [7:0] reg_addr_o, // Offset
    output logic [7:0] reg_wdata_o // Write data
);
    initial {reg_wr_o, reg_rd_o, reg_addr_o, reg_wdata_o} = '0;
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_i);
        #1;
        reg_wr_o = 1'b1;
        reg_addr_o = a;
        reg_wdata_o = v;
        @(posedge clk_i);
        #1;
        reg_wr_o = 1'b0;
        reg_wdata_o = ~v;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk_i);
        #1;
        reg_rd_o = 1'b1;
        reg_addr_o = a;
        @(posedge clk_i);
        #1;
        v = reg_rdata_i;
        reg_rd_o = 1'b0;
    endtask
endmodule // irq_host_model

// ---- tb/tb.sv ----
// Bench: register and event scenarios for the aggregator.
// Assumes the host model owns the register port.
`timescale 1ns/1ps
module tb;
    import irq_agg_pkg::*;
    logic clk_i = 0, nrst_i = 0, tx_i = 0, tx_rd = 0, wr, rd, irq_n;
    logic [7:0] addr, wdata, rdata, d;
    logic [1:0][NUM_LO-1:0] lo_ev = '0;
    logic [1:0][NUM_HI-1:0] hi_ev = '0;
    logic [NUM_PINS-1:0] p_out, p_oe;
    logic [7:0] ra[7] = '{ADDR_MAIN_CTL, ADDR_MAIN_STS, ADDR_EN_HI, ADDR_EN_LO,
        ADDR_FLG_HI, ADDR_FLG_LO, 8'hFF};
    int n_errors = 0, checks_done = 0, cycles = 0;
    irq_aggregator dut (.clk_i(clk_i), .nrst_i(nrst_i), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .lo_event_i(lo_ev),
        .hi_event_i(hi_ev), .tx_irq_i(tx_i), .tx_sts_rd_i(tx_rd),
        .interrupt_out_n_o(irq_n), .pin_out_o(p_out), .pin_oe_o(p_oe));
    irq_host_model host (.clk_i(clk_i), .reg_rdata_i(rdata), .reg_wr_o(wr), .reg_rd_o(rd),
        .reg_addr_o(addr), .reg_wdata_o(wdata));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        host.rd(a, d);
        chk(d, exp);
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial forever #10 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            end_of_test();
        end
    end
    initial begin
        cyc(8);
        nrst_i = 1;
        foreach (ra[i]) rdc(ra[i], 8'h00);
        chk({7'h00, irq_n}, 8'h01);
        host.wr(ADDR_PIN_CTL, 8'h40);
        host.wr(ADDR_PORT_SEL, 8'h01);
        lo_ev[0][2] = 1'b1;
        cyc(1);
        lo_ev[0][2] = 1'b0;
        cyc(4);
        rdc(ADDR_FLG_LO, 8'h04);
        host.wr(ADDR_EN_LO, 8'h04);
        host.wr(ADDR_MAIN_CTL, 8'h01);
        rdc(ADDR_MAIN_STS, 8'h81);
        chk({7'h00, irq_n}, 8'h01);
        host.wr(ADDR_MAIN_CTL, 8'h81);
        cyc(2);
        chk({irq_n, 3'h0, p_oe}, 8'h08);
        chk({4'h0, p_out}, 8'h00);
        rdc(ADDR_MAIN_CTL, 8'h81);
        host.rd(ADDR_CAM_STS, d);
        rdc(ADDR_FLG_LO, 8'h04);
        host.rd(ADDR_LINK_STS2, d);
        cyc(1);
        chk({7'h00, irq_n}, 8'h01);
        host.wr(ADDR_FLG_LO, 8'hFF);
        rdc(ADDR_FLG_LO, 8'h00);
        host.wr(ADDR_PORT_SEL, 8'h02);
        hi_ev[1][0] = 1'b1;
        cyc(1);
        hi_ev[1][0] = 1'b0;
        cyc(4);
        rdc(ADDR_FLG_HI, 8'h01);
        host.wr(ADDR_PORT_SEL, 8'h01);
        rdc(ADDR_FLG_HI, 8'h00);
        host.wr(ADDR_PORT_SEL, 8'h02);
        host.wr(ADDR_EN_HI, 8'h01);
        host.wr(ADDR_MAIN_CTL, 8'h82);
        cyc(1);
        chk({7'h00, irq_n}, 8'h00);
        rdc(ADDR_MAIN_STS, 8'h82);
        host.rd(ADDR_LINK_STS1, d);
        cyc(1);
        chk({7'h00, irq_n}, 8'h01);
        host.wr(ADDR_MAIN_CTL, 8'h90);
        tx_i = 1'b1;
        cyc(6);
        chk({7'h00, irq_n}, 8'h00);
        rdc(ADDR_MAIN_STS, 8'h90);
        tx_i = 1'b0;
        tx_rd = 1'b1;
        cyc(1);
        tx_rd = 1'b0;
        cyc(1);
        chk({7'h00, irq_n}, 8'h01);
        end_of_test();
    end
endmodule // tb
bind irq_aggregator irq_agg_sva chk_u (.clk_i(clk_i), .nrst_i(nrst_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .tx_irq_i(tx_irq_i), .tx_sts_rd_i(tx_sts_rd_i),
    .interrupt_out_n_o(interrupt_out_n_o), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o));
